//--- temp_regs_pkg.sv
// Purpose: shared constants and types for the result/status register block
// Assumes: 16-bit register words, 14-bit signed results, 8-bit addresses
// Notes:   status bits 2..0 belong to neighbouring logic and read as zero
package temp_regs_pkg;

    localparam int RES_W  = 14;  // result field width
    localparam int EXT_W  = 16;  // headroom for limit +/- hysteresis
    localparam int PAD_W  = 2;   // always-zero bits below the result
    localparam int DATA_W = 16;  // register word
    localparam int STAT_W = 8;   // implemented low byte of status
    localparam int ADDR_W = 8;

    localparam logic [ADDR_W-1:0] ADDR_TEMP   = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_SLEW   = 8'h01;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h02;

    localparam int STAT_CRC   = 7;  // checksum fault, read-to-clear
    localparam int STAT_SPOS  = 6;  // live positive slew
    localparam int STAT_SLEWF = 5;  // latched slew event, read-to-clear
    localparam int STAT_HIGH  = 4;  // live high with hysteresis
    localparam int STAT_LOW   = 3;  // live low with hysteresis

    localparam logic [RES_W-1:0]  RESULT_RST = 14'h0000;
    localparam logic [STAT_W-1:0] STATUS_RST = 8'h00;
    localparam logic [DATA_W-1:0] DATA_RST   = 16'h0000;

    // one coherent copy of everything software can read
    typedef struct packed {
        logic [RES_W-1:0]  temp;
        logic [RES_W-1:0]  slew;
        logic [STAT_W-1:0] status;
    } snapshot_s;

    typedef enum logic {
        PUB_IDLE = 1'b0,
        PUB_WAIT = 1'b1
    } pub_state_e;

endpackage

//--- event_xing.sv
// Purpose: carry a one-cycle event from one clock domain to another
// Assumes: events spaced wider than three destination clocks
// Notes:   toggle in source domain, two-flop sync plus edge detect
`timescale 1ns/1ps
module event_xing (
    input  wire logic src_clk_in,
    input  wire logic src_en_in,
    input  wire logic dst_clk_in,
    input  wire logic dst_en_in,
    input  wire logic rst_n_in,
    input  wire logic src_pulse_in,
    output logic      dst_pulse_out
);
    logic tgl_q;
    logic tgl_d;
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // source toggles once per event so no pulse can be too short to see
    always_comb begin
        tgl_d = tgl_q ^ (src_pulse_in & src_en_in);
    end

    always_ff @(posedge src_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tgl_q <= 1'b0;
        end else begin
            tgl_q <= tgl_d;
        end
    end

    // s1 only feeds s2; edge is taken between s2 and s3
    always_ff @(posedge dst_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else if (dst_en_in) begin
            s1_q <= tgl_q;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign dst_pulse_out = (s2_q ^ s3_q) & dst_en_in;
endmodule

//--- temp_result_alert_status_regs.sv
// Purpose: temperature/slew result and alert status registers
// Assumes: conversion engine and limits on mclk; read port and checksum
//          outcome from link framing logic on link_clk_in
// Notes:   core state lives on mclk; the link side keeps a copy that is
//          refreshed through a handshake whenever the core values change
//
// Contract
// - temperature result in bits 15:2, signed
// - temperature bits 1:0 always read zero
// - slew shown after two continuous conversions
// - slew reads zero outside continuous mode
// - slew result in bits 15:2, signed
// - status read clears only on single non-increment read
// - bit7 set on checksum failure, cleared success
// - bit6 live positive slew above limit
// - bit5 latches slew event until status read
// - bit4 high with hysteresis release
// - bit3 low with hysteresis release
// - status read clears fault, releases alert
`timescale 1ns/1ps
module temp_result_alert_status_regs
    import temp_regs_pkg::*;
(
    input  wire logic              mclk_in,
    input  wire logic              rst_n_in,
    input  wire logic              en_in,
    input  wire logic              conv_done_in,
    input  wire logic [RES_W-1:0]  conv_temp_in,
    input  wire logic [RES_W-1:0]  conv_slew_in,
    input  wire logic              cont_mode_in,
    input  wire logic [RES_W-1:0]  high_limit_in,
    input  wire logic [RES_W-1:0]  high_hyst_in,
    input  wire logic [RES_W-1:0]  low_limit_in,
    input  wire logic [RES_W-1:0]  low_hyst_in,
    input  wire logic [RES_W-1:0]  slew_limit_in,
    input  wire logic              link_clk_in,
    input  wire logic              crc_fail_in,
    input  wire logic              crc_ok_in,
    input  wire logic              rd_req_in,
    input  wire logic [ADDR_W-1:0] rd_addr_in,
    input  wire logic              rd_autoinc_in,
    output logic [DATA_W-1:0]      rd_data_out,
    output logic                   alert_out
);
    // core-domain state
    logic [RES_W-1:0] temp_q, temp_d;
    logic [RES_W-1:0] slew_q, slew_d;
    logic             seen_q, seen_d;
    logic             crc_q, crc_d;
    logic             spos_q, spos_d;
    logic             slewf_q, slewf_d;
    logic             high_q, high_d;
    logic             low_q, low_d;
    logic             alert_q, alert_d;
    pub_state_e       pub_q, pub_d;
    snapshot_s        bundle_q, bundle_d;
    snapshot_s        live;
    logic             req_pulse;

    // link-domain state
    snapshot_s        lk_q, lk_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic             clr_link;

    // crossed events
    logic             clr_core;
    logic             fail_core;
    logic             ok_core;
    logic             req_link;
    logic             ack_core;

    // signed comparisons with room for limit +/- hysteresis
    logic signed [EXT_W-1:0] t_x, s_x, hi_x, hclr_x, lo_x, lclr_x, sl_x;
    logic                    slew_over;

    always_comb begin
        t_x    = EXT_W'($signed(conv_temp_in));
        s_x    = EXT_W'($signed(conv_slew_in));
        hi_x   = EXT_W'($signed(high_limit_in));
        lo_x   = EXT_W'($signed(low_limit_in));
        sl_x   = EXT_W'($signed(slew_limit_in));
        hclr_x = hi_x - $signed(EXT_W'(high_hyst_in));
        lclr_x = lo_x + $signed(EXT_W'(low_hyst_in));
        slew_over = (s_x > sl_x);
    end

    // next values of results and flags; set always beats a clear
    always_comb begin
        temp_d  = temp_q;
        slew_d  = slew_q;
        seen_d  = seen_q;
        crc_d   = crc_q;
        spos_d  = spos_q;
        slewf_d = slewf_q;
        high_d  = high_q;
        low_d   = low_q;
        if (conv_done_in) begin
            temp_d = conv_temp_in;
            if (t_x > hi_x) begin
                high_d = 1'b1;
            end else if (t_x < hclr_x) begin
                high_d = 1'b0;
            end
            if (t_x < lo_x) begin
                low_d = 1'b1;
            end else if (t_x > lclr_x) begin
                low_d = 1'b0;
            end
        end
        if (!cont_mode_in) begin
            slew_d = RESULT_RST;
            seen_d = 1'b0;
            spos_d = 1'b0;
        end else if (conv_done_in) begin
            seen_d = 1'b1;
            if (seen_q) begin
                // only the sign of a falling slew is meaningful upstream
                slew_d = conv_slew_in;
                spos_d = slew_over;
            end
        end
        if (fail_core) begin
            crc_d = 1'b1;
        end else if (ok_core || clr_core) begin
            crc_d = 1'b0;
        end
        if (conv_done_in && cont_mode_in && seen_q && slew_over) begin
            slewf_d = 1'b1;
        end else if (clr_core) begin
            slewf_d = 1'b0;
        end
        // alert follows the latched events only; a read drops it
        alert_d = crc_d | slewf_d;
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            temp_q  <= RESULT_RST;
            slew_q  <= RESULT_RST;
            seen_q  <= 1'b0;
            crc_q   <= 1'b0;
            spos_q  <= 1'b0;
            slewf_q <= 1'b0;
            high_q  <= 1'b0;
            low_q   <= 1'b0;
            alert_q <= 1'b0;
        end else if (en_in) begin
            temp_q  <= temp_d;
            slew_q  <= slew_d;
            seen_q  <= seen_d;
            crc_q   <= crc_d;
            spos_q  <= spos_d;
            slewf_q <= slewf_d;
            high_q  <= high_d;
            low_q   <= low_d;
            alert_q <= alert_d;
        end
    end

    // publish a whole snapshot; it holds still until the link acknowledges
    always_comb begin
        live        = '0;
        live.temp   = temp_q;
        live.slew   = slew_q;
        live.status = STATUS_RST;
        live.status[STAT_CRC]   = crc_q;
        live.status[STAT_SPOS]  = spos_q;
        live.status[STAT_SLEWF] = slewf_q;
        live.status[STAT_HIGH]  = high_q;
        live.status[STAT_LOW]   = low_q;
        pub_d     = pub_q;
        bundle_d  = bundle_q;
        req_pulse = 1'b0;
        unique case (pub_q)
            PUB_IDLE: begin
                if (live != bundle_q) begin
                    bundle_d  = live;
                    req_pulse = 1'b1;
                    pub_d     = PUB_WAIT;
                end
            end
            PUB_WAIT: begin
                if (ack_core) begin
                    pub_d = PUB_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pub_q    <= PUB_IDLE;
            bundle_q <= '0;
        end else if (en_in) begin
            pub_q    <= pub_d;
            bundle_q <= bundle_d;
        end
    end

    // link side: capture snapshot, serve reads; no write path exists
    always_comb begin
        lk_d     = lk_q;
        rdata_d  = rdata_q;
        clr_link = 1'b0;
        if (req_link) begin
            lk_d = bundle_q;
        end
        if (rd_req_in) begin
            case (rd_addr_in)
                ADDR_TEMP:   rdata_d = {lk_q.temp, {PAD_W{1'b0}}};
                ADDR_SLEW:   rdata_d = {lk_q.slew, {PAD_W{1'b0}}};
                ADDR_STATUS: rdata_d = {{(DATA_W-STAT_W){1'b0}},
                                        lk_q.status};
                default:     rdata_d = DATA_RST;
            endcase
            // a burst read must not clear; the copy may lag the core
            if (rd_addr_in == ADDR_STATUS && !rd_autoinc_in) begin
                clr_link = 1'b1;
                lk_d.status[STAT_CRC]   = 1'b0;
                lk_d.status[STAT_SLEWF] = 1'b0;
            end
        end
    end

    always_ff @(posedge link_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lk_q    <= '0;
            rdata_q <= DATA_RST;
        end else begin
            lk_q    <= lk_d;
            rdata_q <= rdata_d;
        end
    end

    // event crossings between the two domains
    event_xing u_clr (
        .src_clk_in    (link_clk_in),
        .src_en_in     (1'b1),
        .dst_clk_in    (mclk_in),
        .dst_en_in     (en_in),
        .rst_n_in      (rst_n_in),
        .src_pulse_in  (clr_link),
        .dst_pulse_out (clr_core)
    );
    event_xing u_fail (
        .src_clk_in    (link_clk_in),
        .src_en_in     (1'b1),
        .dst_clk_in    (mclk_in),
        .dst_en_in     (en_in),
        .rst_n_in      (rst_n_in),
        .src_pulse_in  (crc_fail_in),
        .dst_pulse_out (fail_core)
    );
    event_xing u_ok (
        .src_clk_in    (link_clk_in),
        .src_en_in     (1'b1),
        .dst_clk_in    (mclk_in),
        .dst_en_in     (en_in),
        .rst_n_in      (rst_n_in),
        .src_pulse_in  (crc_ok_in),
        .dst_pulse_out (ok_core)
    );
    event_xing u_req (
        .src_clk_in    (mclk_in),
        .src_en_in     (en_in),
        .dst_clk_in    (link_clk_in),
        .dst_en_in     (1'b1),
        .rst_n_in      (rst_n_in),
        .src_pulse_in  (req_pulse),
        .dst_pulse_out (req_link)
    );
    event_xing u_ack (
        .src_clk_in    (link_clk_in),
        .src_en_in     (1'b1),
        .dst_clk_in    (mclk_in),
        .dst_en_in     (en_in),
        .rst_n_in      (rst_n_in),
        .src_pulse_in  (req_link),
        .dst_pulse_out (ack_core)
    );

    assign rd_data_out = rdata_q;
    assign alert_out   = alert_q;

    // checks on the core and link behaviour
    property p_temp_pad;
        @(posedge link_clk_in) disable iff (!rst_n_in)
        rd_req_in && rd_addr_in == ADDR_TEMP
        |=> rd_data_out[PAD_W-1:0] == 2'h0
            && rd_data_out[DATA_W-1:PAD_W] == $past(lk_q.temp);
    endproperty
    a_temp_pad: assert property (p_temp_pad)
        else $error("temperature pad bits or value wrong");

    property p_status_upper;
        @(posedge link_clk_in) disable iff (!rst_n_in)
        rd_req_in && rd_addr_in == ADDR_STATUS
        |=> rd_data_out[DATA_W-1:STAT_W] == 8'h00;
    endproperty
    a_status_upper: assert property (p_status_upper)
        else $error("status upper byte not zero");

    property p_slew_off;
        @(posedge mclk_in) disable iff (!rst_n_in)
        en_in && !cont_mode_in |=> slew_q == RESULT_RST && !spos_q;
    endproperty
    a_slew_off: assert property (p_slew_off)
        else $error("slew not cleared outside continuous mode");

    property p_slew_first;
        @(posedge mclk_in) disable iff (!rst_n_in)
        en_in && conv_done_in && cont_mode_in && !seen_q
        |=> $stable(slew_q) && seen_q;
    endproperty
    a_slew_first: assert property (p_slew_first)
        else $error("slew shown after a single conversion");

    property p_crc_set;
        @(posedge mclk_in) disable iff (!rst_n_in)
        en_in && fail_core |=> crc_q ##1 alert_q;
    endproperty
    a_crc_set: assert property (p_crc_set)
        else $error("checksum fault not flagged");

    property p_crc_clear;
        @(posedge mclk_in) disable iff (!rst_n_in)
        en_in && (ok_core || clr_core) && !fail_core |=> !crc_q;
    endproperty
    a_crc_clear: assert property (p_crc_clear)
        else $error("checksum fault not cleared");

    property p_spos_live;
        @(posedge mclk_in) disable iff (!rst_n_in)
        en_in && conv_done_in && cont_mode_in && seen_q
        |=> spos_q == $past(slew_over) && slew_q == $past(conv_slew_in);
    endproperty
    a_spos_live: assert property (p_spos_live)
        else $error("live slew bit disagrees with slew");

    property p_slewf_hold;
        @(posedge mclk_in) disable iff (!rst_n_in)
        en_in && slewf_q && !clr_core |=> slewf_q;
    endproperty
    a_slewf_hold: assert property (p_slewf_hold)
        else $error("slew event dropped without a read");

    property p_high_set;
        @(posedge mclk_in) disable iff (!rst_n_in)
        en_in && conv_done_in && t_x > hi_x
        |=> high_q && temp_q == $past(conv_temp_in);
    endproperty
    a_high_set: assert property (p_high_set)
        else $error("high status not set");

    property p_low_set;
        @(posedge mclk_in) disable iff (!rst_n_in)
        en_in && conv_done_in && t_x < lo_x |=> low_q;
    endproperty
    a_low_set: assert property (p_low_set)
        else $error("low status not set");

    property p_bundle_still;
        @(posedge mclk_in) disable iff (!rst_n_in)
        pub_q == PUB_WAIT && !ack_core |=> $stable(bundle_q);
    endproperty
    a_bundle_still: assert property (p_bundle_still)
        else $error("snapshot moved during handover");
endmodule

//--- link_host_model.sv
// Purpose: link-side host that reads the result and status registers
// Assumes: link clock runs free, one request per task call
// Notes:   outputs change at the falling link edge, away from sampling
`timescale 1ns/1ps
module link_host_model
    import temp_regs_pkg::*;
(
    input  wire logic              link_clk_in,
    input  wire logic [DATA_W-1:0] rd_data_in,
    output logic                   rd_req_out,
    output logic [ADDR_W-1:0]      rd_addr_out,
    output logic                   rd_autoinc_out,
    output logic                   crc_fail_out,
    output logic                   crc_ok_out
);
    // idle levels; the address line carries no stale copy of a request
    initial begin
        rd_req_out     = 1'b0;
        rd_addr_out    = 8'hA5;
        rd_autoinc_out = 1'b0;
        crc_fail_out   = 1'b0;
        crc_ok_out     = 1'b0;
    end

    // one read: held over one rising edge, data stands until next read
    task automatic read(input logic [ADDR_W-1:0] addr, input logic inc,
                        output logic [DATA_W-1:0] data);
        @(negedge link_clk_in);
        rd_req_out     = 1'b1;
        rd_addr_out    = addr;
        rd_autoinc_out = inc;
        @(negedge link_clk_in);
        rd_req_out     = 1'b0;
        rd_addr_out    = ~addr;  // released lines show the inverse
        rd_autoinc_out = ~inc;
        @(negedge link_clk_in);
        data = rd_data_in;
    endtask

    // outcome of one protected write, a single link pulse
    task automatic checksum(input logic fail);
        @(negedge link_clk_in);
        crc_fail_out = fail;
        crc_ok_out   = ~fail;
        @(negedge link_clk_in);
        crc_fail_out = 1'b0;
        crc_ok_out   = 1'b0;
    endtask
endmodule

//--- tb_temp_result_alert_status_regs.sv
// Purpose: self-checking bench for the result and status registers
// Assumes: link host model issues reads and checksum outcomes
// Notes:   reference model keeps results as integers and flags as single bits
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin samples_checked++; \
    if ((gt) !== (ex)) begin fails++; \
    $display("MISMATCH %s exp=%h got=%h", nm, ex, gt); end end
module tb_temp_result_alert_status_regs import temp_regs_pkg::*;;
    logic              mclk_in, rst_n_in, en_in, conv_done_in;
    logic [RES_W-1:0]  conv_temp_in, conv_slew_in;
    logic              cont_mode_in, link_clk_in;
    logic              crc_fail_in, crc_ok_in, rd_req_in, rd_autoinc_in;
    logic [ADDR_W-1:0] rd_addr_in;
    logic [DATA_W-1:0] rd_data_out;
    logic              alert_out;
    int                fails, samples_checked, seed, cnt, e_t, e_s;
    logic              e_crc, e_spos, e_slewf, e_hi, e_lo;
    int                tv[6] = '{2100, 1900, 1700, -2100, -1900, -1700};
    // limits as the model sees them
    localparam int HH = 256, LL = -2048, LH = 256;
    // high and slew limits are driven so a scenario can move them
    int                hl = 2048, sl = 512;

    // clocks: core 40 ns, link 30 ns with its own phase
    initial mclk_in = 1'b0;
    always #20 mclk_in = ~mclk_in;
    initial link_clk_in = 1'b0;
    always begin
        #7;
        forever #15 link_clk_in = ~link_clk_in;
    end

    temp_result_alert_status_regs temp_result_alert_status_regs_inst (
        .mclk_in(mclk_in), .rst_n_in(rst_n_in), .en_in(en_in),
        .conv_done_in(conv_done_in), .conv_temp_in(conv_temp_in),
        .conv_slew_in(conv_slew_in), .cont_mode_in(cont_mode_in),
        .high_limit_in(hl[RES_W-1:0]), .high_hyst_in(14'h0100),
        .low_limit_in(14'h3800), .low_hyst_in(14'h0100),
        .slew_limit_in(sl[RES_W-1:0]), .link_clk_in(link_clk_in),
        .crc_fail_in(crc_fail_in), .crc_ok_in(crc_ok_in),
        .rd_req_in(rd_req_in), .rd_addr_in(rd_addr_in),
        .rd_autoinc_in(rd_autoinc_in), .rd_data_out(rd_data_out),
        .alert_out(alert_out));

    link_host_model link_host_model_inst (
        .link_clk_in(link_clk_in), .rd_data_in(rd_data_out),
        .rd_req_out(rd_req_in), .rd_addr_out(rd_addr_in),
        .rd_autoinc_out(rd_autoinc_in), .crc_fail_out(crc_fail_in),
        .crc_ok_out(crc_ok_in));

    task automatic stop_test();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic model_reset();
        {e_crc, e_spos, e_slewf, e_hi, e_lo} = 5'h00;
        e_t = 0;
        e_s = 0;
        cnt = 0;
    endtask

    // status word as the model expects it; bits 2..0 are not ours
    function automatic logic [DATA_W-1:0] exp_status();
        return {8'h00, e_crc, e_spos, e_slewf, e_hi, e_lo, 3'h0};
    endfunction

    // leaving continuous mode drops the slew result and restarts the count
    task automatic set_mode(input logic cm);
        @(negedge mclk_in);
        cont_mode_in = cm;
        if (!cm) begin
            e_s = 0;
            e_spos = 1'b0;
            cnt = 0;
        end
        repeat (24) @(negedge mclk_in);
    endtask

    // one conversion strobe; spacing leaves room for the snapshot to cross
    task automatic convert(input int t, input int s);
        @(negedge mclk_in);
        conv_done_in = 1'b1;
        conv_temp_in = t[RES_W-1:0];
        conv_slew_in = s[RES_W-1:0];
        @(negedge mclk_in);
        conv_done_in = 1'b0;
        conv_temp_in = ~conv_temp_in;  // data is only valid with the strobe
        conv_slew_in = ~conv_slew_in;
        if (en_in) begin
            e_t = t;
            if (t > hl) e_hi = 1'b1; else if (t < hl - HH) e_hi = 1'b0;
            if (t < LL) e_lo = 1'b1; else if (t > LL + LH) e_lo = 1'b0;
            if (cont_mode_in) cnt++;
            if (cnt >= 2) begin
                e_s = s;
                e_spos = s > sl;
                if (s > sl) e_slewf = 1'b1;
            end
        end
        repeat (24) @(negedge mclk_in);
    endtask

    // burst reads of every register, none of which may clear a flag
    task automatic check_all();
        logic [DATA_W-1:0] d;
        logic [ADDR_W-1:0] a;
        link_host_model_inst.read(ADDR_TEMP, 1'b1, d);
        `CHK("temp", {e_t[RES_W-1:0], 2'b00}, d)
        link_host_model_inst.read(ADDR_SLEW, 1'b1, d);
        if (e_s < 0) begin
            `CHK("slew sign", 1'b1, d[15])
        end else begin
            `CHK("slew", {e_s[RES_W-1:0], 2'b00}, d)
        end
        link_host_model_inst.read(ADDR_STATUS, 1'b1, d);
        `CHK("status", exp_status(), d)
        a = 8'h03 + 8'($unsigned($random(seed)) % 253);
        link_host_model_inst.read(a, 1'b0, d);
        `CHK("unmapped", 16'h0000, d)
        `CHK("alert", e_crc | e_slewf, alert_out)
    endtask

    // single non-incrementing status read clears the latched flags
    task automatic clear_status();
        logic [DATA_W-1:0] d;
        link_host_model_inst.read(ADDR_STATUS, 1'b0, d);
        `CHK("status rd", exp_status(), d)
        e_crc = 1'b0;
        e_slewf = 1'b0;
        repeat (12) @(negedge mclk_in);
        check_all();
    endtask

    task automatic crc_event(input logic fail);
        link_host_model_inst.checksum(fail);
        e_crc = fail;
        repeat (10) @(negedge mclk_in);
        check_all();
    endtask

    // watchdog sized well above the expected run of about 56 us
    initial begin
        #1000000;
        fails++;
        stop_test();
    end

    // main sequence
    initial begin
        seed = 32'hCE7E;
        {rst_n_in, conv_done_in, cont_mode_in} = 3'h0;
        en_in = 1'b1;
        conv_temp_in = 14'h0000;
        conv_slew_in = 14'h0000;
        model_reset();
        repeat (16) @(negedge mclk_in);
        rst_n_in = 1'b1;
        repeat (4) @(negedge mclk_in);
        check_all();
        convert(300, 900);
        set_mode(1'b1);
        convert(2100, 100);
        check_all();
        foreach (tv[i]) begin
            convert(tv[i], 600 - 200 * i);
            check_all();
        end
        // lower both limits so random data crosses them from both sides
        @(negedge mclk_in);
        hl = 1500;
        sl = 300;
        for (int i = 0; i < 20; i++) begin
            convert($random(seed) % 3000, $random(seed) % 1024);
            check_all();
            if (i % 4 == 3) clear_status();
        end
        convert(100, 800);
        link_host_model_inst.checksum(1'b1);
        e_crc = 1'b1;
        repeat (10) @(negedge mclk_in);
        check_all();
        clear_status();
        crc_event(1'b1);
        crc_event(1'b0);
        @(negedge mclk_in);
        en_in = 1'b0;
        convert(5000, 700);
        en_in = 1'b1;
        check_all();
        set_mode(1'b0);
        check_all();
        set_mode(1'b1);
        convert(-500, 300);
        check_all();
        @(negedge mclk_in);
        rst_n_in = 1'b0;
        repeat (3) @(negedge mclk_in);
        rst_n_in = 1'b1;
        model_reset();
        repeat (4) @(negedge mclk_in);
        check_all();
        stop_test();
    end
endmodule
